// ==== pkg/sbcf_defines.vh ====
// Constants for the serial bit-rate and card-format channel
`ifndef SBCF_DEFINES_VH
`define SBCF_DEFINES_VH
// Word offsets on the register bus (word index, byte address / 4)
`define SBCF_OFF_MODE      6'h00
`define SBCF_OFF_CARD      6'h01
`define SBCF_OFF_RATE      6'h02
`define SBCF_OFF_DATA      6'h03
`define SBCF_OFF_STAT      6'h04
// serial_mode_register fields
`define SBCF_MODE_CKS_LO   0
`define SBCF_MODE_CKS_HI   1
`define SBCF_MODE_BCP_LO   2
`define SBCF_MODE_BCP_HI   3
`define SBCF_MODE_ODD      4
`define SBCF_MODE_SEVEN    5
`define SBCF_MODE_SYNC     6
`define SBCF_MODE_RXEN     7
`define SBCF_MODE_RESET    8'h00
// card_mode_control fields
`define SBCF_CARD_SEL      0
`define SBCF_CARD_INV      2
`define SBCF_CARD_DIR      3
`define SBCF_CARD_RSVD     8'hf2
`define SBCF_CARD_RESET    8'hf2
// status fields
`define SBCF_STAT_TXBUSY   0
`define SBCF_STAT_RXFULL   1
// bit_rate_divider reset
`define SBCF_RATE_RESET    8'hff
// Basic clocks per bit, after the 4^n prescaler; card values are S, doubled to 2*S per bit
`define SBCF_BASE_ASYNC    10'h020
`define SBCF_BASE_SYNC     10'h004
`define SBCF_CARD_S0       10'h020
`define SBCF_CARD_S1       10'h040
`define SBCF_CARD_S2       10'h174
`define SBCF_CARD_S3       10'h100
// Last prescaler count for each clock-select code, one enable per 4^n clocks
`define SBCF_PRE_LAST0     6'h00
`define SBCF_PRE_LAST1     6'h03
`define SBCF_PRE_LAST2     6'h0f
`define SBCF_PRE_LAST3     6'h3f
`endif

// ==== src/sbcf_top.v ====
// Serial channel bit-rate generator, card format control and bit shifter
`timescale 1ns/1ps
`include "sbcf_defines.vh"
module sbcf_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        rxd_i,
   output reg         txd_o,
   output reg         bit_tick_o,
   output reg         card_mode_o
);

   // Bit order and inversion; reversal is its own inverse, so rx reuses it
   function [7:0] sbcf_xform;
      input [7:0] d;
      input       msb_first;
      input       seven;
      input       inv;
      reg   [7:0] o;
      integer     i;
      begin
         o = d;
         if (msb_first && !seven) begin
            for (i = 0; i < 8; i = i + 1)
               o[i] = d[7 - i];
         end
         if (inv)
            o = ~o;
         if (seven)
            o[7] = 1'b0;
         sbcf_xform = o;
      end
   endfunction

   // Access strobe for one register word
   function sbcf_hit;
      input       req;
      input [5:0] word;
      input [5:0] off;
      begin
         sbcf_hit = req && (word == off);
      end
   endfunction

   // Read mux; unmapped words read zero so probing is harmless
   function [7:0] sbcf_read;
      input [5:0] word;
      input [7:0] mode;
      input [7:0] card;
      input [7:0] rate;
      input [7:0] rxbuf;
      input       full;
      input       busy;
      begin
         case (word)
            `SBCF_OFF_MODE: sbcf_read = mode;
            `SBCF_OFF_CARD: sbcf_read = card;
            `SBCF_OFF_RATE: sbcf_read = rate;
            `SBCF_OFF_DATA: sbcf_read = rxbuf;
            `SBCF_OFF_STAT: sbcf_read = {6'h00, full, busy};
            default:        sbcf_read = 8'h00;
         endcase
      end
   endfunction

   reg  [7:0] serial_mode_register;
   reg  [7:0] card_mode_control;
   reg  [7:0] bit_rate_divider;
   reg  [7:0] receive_buffer;
   reg        rx_full;

   wire [1:0] prescale_select = {serial_mode_register[`SBCF_MODE_CKS_HI],
                                 serial_mode_register[`SBCF_MODE_CKS_LO]};
   wire [1:0] cycles_per_bit  = {serial_mode_register[`SBCF_MODE_BCP_HI],
                                 serial_mode_register[`SBCF_MODE_BCP_LO]};
   wire       odd_parity      = serial_mode_register[`SBCF_MODE_ODD];
   wire       seven_bit       = serial_mode_register[`SBCF_MODE_SEVEN];
   wire       sync_mode       = serial_mode_register[`SBCF_MODE_SYNC];
   wire       rx_enable       = serial_mode_register[`SBCF_MODE_RXEN];
   wire       card_mode_select = card_mode_control[`SBCF_CARD_SEL];
   wire       data_invert     = card_mode_control[`SBCF_CARD_INV];
   wire       bit_order_select = card_mode_control[`SBCF_CARD_DIR];

   // Bus decode
   wire       bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire       bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
   wire [5:0] word_adr = wb_adr_i[7:2];

   // Prescaler: one enable every 4^n clocks
   reg  [5:0] pre_cnt;
   reg  [5:0] pre_last;
   wire       pre_tick = (pre_cnt == pre_last);

   always @* begin
      case (prescale_select)
         2'b00:   pre_last = `SBCF_PRE_LAST0;
         2'b01:   pre_last = `SBCF_PRE_LAST1;
         2'b10:   pre_last = `SBCF_PRE_LAST2;
         2'b11:   pre_last = `SBCF_PRE_LAST3;
         default: pre_last = `SBCF_PRE_LAST0;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i)
         pre_cnt <= 6'h00;
      else if (pre_tick)
         pre_cnt <= 6'h00;
      else
         pre_cnt <= pre_cnt + 6'h01;
   end

   // Rate divider private to this channel; reload picks up a new N
   reg  [7:0] div_cnt;
   wire       base_tick = pre_tick && (div_cnt == 8'h00);

   reg  [7:0] next_div_cnt;

   always @* begin
      next_div_cnt = div_cnt;
      if (base_tick)
         next_div_cnt = bit_rate_divider;
      else if (pre_tick)
         next_div_cnt = div_cnt - 8'h01;
   end

   always @(posedge clk_i) begin
      if (rst_i)
         div_cnt <= `SBCF_RATE_RESET;
      else
         div_cnt <= next_div_cnt;
   end

   // Basic clocks per bit; async 32, sync 4, card 2*S after 4^n
   reg  [9:0] base_per_bit;
   reg  [9:0] card_s;

   always @* begin
      case (cycles_per_bit)
         2'b00:   card_s = `SBCF_CARD_S0;
         2'b01:   card_s = `SBCF_CARD_S1;
         2'b10:   card_s = `SBCF_CARD_S2;
         2'b11:   card_s = `SBCF_CARD_S3;
         default: card_s = `SBCF_CARD_S0;
      endcase
      if (card_mode_select)
         base_per_bit = {card_s[8:0], 1'b0};
      else if (sync_mode)
         base_per_bit = `SBCF_BASE_SYNC;
      else
         base_per_bit = `SBCF_BASE_ASYNC;
   end

   // Counting 2*S in ten bits is safe: largest is 744
   reg  [9:0] bit_cnt;
   wire       bit_end = base_tick && (bit_cnt == base_per_bit - 10'h001);

   always @(posedge clk_i) begin
      if (rst_i) begin
         bit_cnt    <= 10'h000;
         bit_tick_o <= 1'b0;
      end else begin
         bit_tick_o <= bit_end;
         if (bit_end)
            bit_cnt <= 10'h000;
         else if (base_tick)
            bit_cnt <= bit_cnt + 10'h001;
         // A mode change can leave the count past the end; restart it
         if (bit_cnt >= base_per_bit)
            bit_cnt <= 10'h000;
      end
   end

   // Transmitter: data bits on bit ticks, then the parity bit
   reg  [7:0] tx_shift;
   reg  [3:0] tx_cnt;
   reg        tx_parity;
   wire       tx_busy = (tx_cnt != 4'h0);
   wire [3:0] data_bits = seven_bit ? 4'h7 : 4'h8;
   wire [7:0] tx_plain  = seven_bit ? {1'b0, wb_dat_i[6:0]} : wb_dat_i[7:0];

   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_shift  <= 8'h00;
         tx_cnt    <= 4'h0;
         tx_parity <= 1'b0;
         txd_o     <= 1'b1;
      end else begin
         if (sbcf_hit(bus_wr, word_adr, `SBCF_OFF_DATA) && !tx_busy) begin
            tx_shift  <= sbcf_xform(wb_dat_i[7:0], bit_order_select,
                                    seven_bit, data_invert);
            // Parity from buffer contents, before inversion
            tx_parity <= (^tx_plain) ^ odd_parity;
            tx_cnt    <= data_bits + 4'h1;
         end else if (bit_end && tx_busy) begin
            tx_cnt <= tx_cnt - 4'h1;
            if (tx_cnt == 4'h1) begin
               txd_o <= tx_parity;
            end else begin
               txd_o    <= tx_shift[0];
               tx_shift <= {1'b0, tx_shift[7:1]};
            end
         end else if (bit_end)
            txd_o <= 1'b1;
      end
   end

   // Receiver: line bits sampled on bit ticks, first bit lands in bit 0
   // No framing: word alignment is set by when receive enable lands
   reg  [7:0] rx_shift;
   reg  [3:0] rx_cnt;
   wire [7:0] rx_next = {rxd_i, rx_shift[7:1]};
   wire [7:0] rx_word = seven_bit ? {1'b0, rx_next[7:1]} : rx_next;
   wire       rx_done = rx_enable && bit_end && (rx_cnt == data_bits - 4'h1);
   wire       rd_data = sbcf_hit(bus_req && !wb_we_i, word_adr, `SBCF_OFF_DATA);

   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_shift       <= 8'h00;
         rx_cnt         <= 4'h0;
         receive_buffer <= 8'h00;
         rx_full        <= 1'b0;
      end else begin
         if (!rx_enable)
            rx_cnt <= 4'h0;
         else if (bit_end) begin
            rx_shift <= rx_next;
            rx_cnt   <= rx_done ? 4'h0 : rx_cnt + 4'h1;
         end
         if (rx_done)
            receive_buffer <= sbcf_xform(rx_word, bit_order_select,
                                         seven_bit, data_invert);
         // Set wins over the clear a read makes
         if (rx_done)
            rx_full <= 1'b1;
         else if (rd_data)
            rx_full <= 1'b0;
      end
   end

   // Mode register: prescaler, cycles per bit, format, receive enable
   always @(posedge clk_i) begin
      if (rst_i)
         serial_mode_register <= `SBCF_MODE_RESET;
      else if (sbcf_hit(bus_wr, word_adr, `SBCF_OFF_MODE))
         serial_mode_register <= wb_dat_i[7:0];
   end

   // Reserved card bits forced high, so writes cannot clear them
   always @(posedge clk_i) begin
      if (rst_i)
         card_mode_control <= `SBCF_CARD_RESET;
      else if (sbcf_hit(bus_wr, word_adr, `SBCF_OFF_CARD))
         card_mode_control <= wb_dat_i[7:0] | `SBCF_CARD_RSVD;
   end

   // The divider only picks up a new N at its next reload
   always @(posedge clk_i) begin
      if (rst_i)
         bit_rate_divider <= `SBCF_RATE_RESET;
      else if (sbcf_hit(bus_wr, word_adr, `SBCF_OFF_RATE))
         bit_rate_divider <= wb_dat_i[7:0];
   end

   // Bus answer one cycle after the request, no wait states
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h0000_0000;
         card_mode_o <= 1'b0;
      end else begin
         wb_ack_o    <= bus_req;
         card_mode_o <= card_mode_select;
         if (bus_req && !wb_we_i)
            wb_dat_o <= {24'h000000, sbcf_read(word_adr, serial_mode_register,
                                                card_mode_control, bit_rate_divider,
                                                receive_buffer, rx_full, tx_busy)};
      end
   end

endmodule // sbcf_top

// ==== verification/sbcf_checker.sv ====
// Assertions on the channel's register bus and line outputs
`timescale 1ns/1ps
module sbcf_checker (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        rxd_i,
   input wire        txd_o,
   input wire        bit_tick_o,
   input wire        card_mode_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   reg  [7:0] rate_q;
   reg        card_wr_q;
   wire       wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
   wire       rd_ack = wb_ack_o && !wb_we_i;
   // Shadow of the rate register, so reads are judged against writes
   always @(posedge clk_i) begin
      if (rst_i)
         rate_q <= 8'hff;
      else if (wr_ack && wb_adr_i == 8'h08)
         rate_q <= wb_dat_i[7:0];
      card_wr_q <= wr_ack && wb_adr_i == 8'h04;
   end
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_req |=> s_ans;
   endproperty
   a_ack: assert property (p_ack) else $error("ack late or long");
   property p_hi_zero;
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
   property p_rate;
      rd_ack && wb_adr_i == 8'h08 |-> wb_dat_o[7:0] == rate_q;
   endproperty
   a_rate: assert property (p_rate) else $error("rate readback wrong");
   property p_rsvd;
      rd_ack && wb_adr_i == 8'h04 |-> wb_dat_o[7:4] == 4'hf && wb_dat_o[1];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved card bits low");
   property p_unmap;
      rd_ack && wb_adr_i[7:2] > 6'h04 |-> wb_dat_o == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_card;
      !$stable(card_mode_o) |-> (wr_ack && wb_adr_i == 8'h04) || card_wr_q;
   endproperty
   a_card: assert property (p_card) else $error("card mode moved alone");
   property p_gap;
      bit_tick_o |=> !bit_tick_o [*3];
   endproperty
   a_gap: assert property (p_gap) else $error("bit ticks too close");
   property p_hold;
      !bit_tick_o |-> $stable(txd_o);
   endproperty
   a_hold: assert property (p_hold) else $error("line moved off tick");
endmodule // sbcf_checker
bind sbcf_top sbcf_checker chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i),
   .txd_o(txd_o), .bit_tick_o(bit_tick_o), .card_mode_o(card_mode_o));

// ==== verification/sbcf_peer.sv ====
// Line-side peer: loops the sent line back to the receive input
`timescale 1ns/1ps
module sbcf_peer (
   input  wire txd_i,
   output wire rxd_o
);
   assign rxd_o = txd_i;
endmodule // sbcf_peer

// ==== verification/sbcf_bench.sv ====
// Self-checking bench for the bit-rate and card-format channel
`timescale 1ns/1ps
module sbcf_bench;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00, d, m;
   logic [31:0] wdat = 32'h0, rdat;
   wire  [31:0] dat_o;
   wire         ack, rxd, txd, tick, card;
   int          miscompares = 0, checked = 0, c;
   always #10 clk_i = ~clk_i;
   sbcf_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .rxd_i(rxd), .txd_o(txd), .bit_tick_o(tick), .card_mode_o(card));
   sbcf_peer peer (.txd_i(txd), .rxd_o(rxd));
   task automatic check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      if (miscompares == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Request held until ack is sampled, then one idle cycle
   task automatic bus(input logic w, input logic [7:0] a, dv);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, dv};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_tick(input int k);
      repeat (k) begin
         c = 0;
         do begin
            @(posedge clk_i);
            c++;
         end while (tick !== 1'b1);
      end
   endtask
   function automatic logic exp_bit(logic [7:0] v, int k, logic sev, dir, inv, odd);
      logic [7:0] w;
      w = inv ? ~v : v;
      // Parity always over the unflipped data
      if (k == (sev ? 7 : 8)) return (sev ? ^v[6:0] : ^v) ^ odd;
      return (dir && !sev) ? w[7-k] : w[k];
   endfunction
   function automatic int exp_period(logic [7:0] mv, logic cm, logic [7:0] nr);
      int s;
      case (mv[3:2])
         2'd0: s = 32;
         2'd1: s = 64;
         2'd2: s = 372;
         default: s = 256;
      endcase
      s = cm ? 2 * s : (mv[6] ? 4 : 32);
      return s * (1 << (2 * mv[1:0])) * (nr + 1);
   endfunction
   initial begin
      void'($urandom(32'h2bd5e0de));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(0, 8'h08, 0);
      check("rate", rdat, 32'hff);
      bus(0, 8'h04, 0);
      check("card", rdat, 32'hf2);
      bus(0, 8'h14, 0);
      check("unmapped", rdat, 32'h0);
      repeat (3) begin
         d = 8'($urandom);
         bus(1, 8'h04, d);
         bus(1, 8'h08, ~d);
         bus(0, 8'h04, 0);
         check("card", rdat, {24'h0, d | 8'hf2});
         bus(0, 8'h08, 0);
         check("rate", rdat, {24'h0, ~d});
      end
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom % 2);
         m = {1'b0, i[0], 2'b00, i[1:0], 2'b00};
         if (i < 4) m[0] = 1'($urandom);
         bus(1, 8'h08, d);
         bus(1, 8'h00, m);
         bus(1, 8'h04, {7'h0, i[2]});
         // New divider only lands at a reload
         wait_tick(3);
         check("card_mode", card, i[2]);
         check("period", 32'(c), exp_period(m, i[2], d));
      end
      bus(1, 8'h08, 8'h03);
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         m = {2'b01, i[0], 1'($urandom), 4'h0};
         bus(1, 8'h00, m);
         bus(1, 8'h04, {4'h0, i[2:1], 2'b00});
         wait_tick(2);
         bus(1, 8'h0c, d);
         for (int k = 0; k < 9 - i[0]; k++) begin
            wait_tick(1);
            check("txd", txd, exp_bit(d, k, i[0], i[2], i[1], m[4]));
            // Receiver enabled so its first sample is data bit 0
            if (k == 0) bus(1, 8'h00, m | 8'h80);
         end
         bus(0, 8'h10, 0);
         check("status", rdat, 32'h2);
         bus(0, 8'h0c, 0);
         check("rx_data", rdat, {24'h0, i[0] ? {1'b0, d[6:0]} : d});
         bus(0, 8'h10, 0);
         check("status_clear", rdat, 32'h0);
      end
      report_and_stop();
   end
   initial begin
      #2_000_000;
      miscompares++;
      report_and_stop();
   end
endmodule // sbcf_bench
